// ==== isr_fifo.v ====
`timescale 1ns/100ps
// ====================================================================
// small sample buffer between converter and pixel chain
module isr_fifo #(
  parameter W = 12,
  parameter D = 4,
  parameter AW = 2
) (
  input  wire          clk,
  input  wire          rst_b,
  input  wire [W-1:0]  in_data,
  input  wire          in_valid,
  output reg           in_ready,
  output wire [W-1:0]  out_data,
  output wire          out_valid,
  input  wire          out_ready
);
  reg  [W-1:0] mem [0:D-1];
  reg  [AW-1:0] wptr_reg;
  reg  [AW-1:0] rptr_reg;
  reg  [AW:0]   count_reg;
  localparam [AW:0] DEPTH = D;
  wire          push = in_valid & in_ready;
  wire          pop  = out_valid & out_ready;
  wire [AW:0]   count_next = count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  assign out_valid = (count_reg != {(AW+1){1'b0}});
  assign out_data  = mem[rptr_reg];

  always @(posedge clk) begin
    if (push) begin
      mem[wptr_reg] <= in_data;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wptr_reg  <= {AW{1'b0}};
      rptr_reg  <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
      in_ready  <= 1'b0;
    end else begin
      if (push) wptr_reg <= wptr_reg + 1'b1;
      if (pop) rptr_reg <= rptr_reg + 1'b1;
      count_reg <= count_next;
      // registered ready: full is known one edge ahead
      in_ready  <= (count_next < DEPTH);
    end
  end
endmodule // isr_fifo

// ==== isr_host_rx.sv ====
`timescale 1ns/100ps
// ====================================================================
// host receiver: samples on rising pixel clock, counts columns and lines
module isr_host_rx (
  input  wire        clk,
  input  wire        rst_b,
  input  wire        pixel_out_clock,
  input  wire        frame_valid,
  input  wire        line_valid,
  input  wire [11:0] pixel_data_out,
  output logic       px_stb,
  output logic [11:0] px_data,
  output logic [15:0] px_col,
  output logic [15:0] px_line,
  output logic       eol_stb,
  output logic       eof_stb,
  output logic [15:0] n_cols,
  output logic [15:0] n_lines
);
  logic        pclk_d, lv_d, fv_d;
  logic [15:0] col, line;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      {pclk_d, lv_d, fv_d, px_stb, eol_stb, eof_stb} <= '0;
      col <= '0;
      line <= '0;
    end else begin
      pclk_d <= pixel_out_clock;
      {px_stb, eol_stb, eof_stb} <= '0;
      // qualifiers and data are taken only on the rising pixel clock
      if (pixel_out_clock && !pclk_d) begin
        lv_d <= line_valid;
        fv_d <= frame_valid;
        if (line_valid) begin
          px_stb <= 1'b1;
          px_data <= pixel_data_out;
          px_col <= col;
          px_line <= line;
          col <= col + 16'h0001;
        end
        if (lv_d && !line_valid) begin
          eol_stb <= 1'b1;
          n_cols <= col;
          col <= '0;
          line <= line + 16'h0001;
        end
        if (fv_d && !frame_valid) begin
          eof_stb <= 1'b1;
          n_lines <= line + 16'(lv_d && !line_valid);
          line <= '0;
        end
      end
    end
  end
endmodule // isr_host_rx

// ==== isr_readout.v ====
`timescale 1ns/100ps
`include "isr_regs.vh"
// Functional notes
// - all timing derived from one input clock
// - parallel mode drives qualifiers plus pixel clock
// - optional embedded data, first/last two lines
// - output pixel rate capped at 74.25 MHz
// - rows stepped in turn: reset, later read
// - exposure is rows between reset and read
// - converter delivers one 12-bit sample per pixel, two per pixel in HDR mode
// - corrections and digital gain before formatting
// - HDR merges exposures into 16-bit pixel
// - compression maps 16-bit value to 12 bits
// - digital output drives external mechanical shutter
// - data valid at pixel clock rising edge
// - qualifiers high while frame/line data valid
// - reset restores every setting to default
// - active-low enable gates the parallel outputs
module isr_readout #(
  parameter COLS   = `ISR_COLS,
  parameter ROWS   = `ISR_ROWS,
  parameter HBLANK = `ISR_HBLANK,
  parameter VBLANK = `ISR_VBLANK
) (
  input  wire        clk,
  input  wire        rst_b,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        master_input_clock,
  input  wire        oe_b,
  input  wire [11:0] adc_sample,
  input  wire        adc_valid,
  output wire        adc_ready,
  output reg  [11:0] pixel_data_out,
  output reg         frame_valid,
  output reg         line_valid,
  output reg         pixel_out_clock,
  output reg         par_oe,
  output reg         row_reset_strobe,
  output reg  [10:0] row_reset_addr,
  output reg         row_read_strobe,
  output reg  [10:0] row_read_addr,
  output reg         shutter_ctrl,
  output reg         raised_common_mode_sel
);
  localparam [2:0] S_VB   = 3'b001;
  localparam [2:0] S_LINE = 3'b010;
  localparam [2:0] S_HB   = 3'b100;
  localparam [10:0] COLS_L = COLS - 1;
  localparam [10:0] ROWS_W = ROWS;
  localparam [10:0] HB_L   = HBLANK - 1;
  localparam [10:0] VB_L   = VBLANK - 1;
  localparam [10:0] EMB_N  = `ISR_EMB_LINES;

  // ==================================================================
  // registers
  reg  [`ISR_CTRL_W-1:0] ctrl_reg;
  reg  [10:0] exposure_reg;
  reg  [7:0]  gain_reg;
  reg  [11:0] black_reg;
  reg  [15:0] frame_cnt_reg;
  reg  [7:0]  awaddr_reg;
  reg  [31:0] wdata_reg;
  reg  [3:0]  wstrb_reg;
  reg         aw_have_reg;
  reg         w_have_reg;
  reg  [15:0] hist_reg [0:3];

  wire stream_en = ctrl_reg[`ISR_CTRL_STREAM];
  wire pll_en    = ctrl_reg[`ISR_CTRL_PLL];
  wire emb_en    = ctrl_reg[`ISR_CTRL_EMB];
  wire hdr_en    = ctrl_reg[`ISR_CTRL_HDR];
  wire comp_en   = ctrl_reg[`ISR_CTRL_COMP];

  // ==================================================================
  // AXI4-Lite slave: address and data may come in either order
  wire wr_go = aw_have_reg & w_have_reg & ~s_axi_bvalid;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `ISR_RESP_OKAY;
      aw_have_reg   <= 1'b0;
      w_have_reg    <= 1'b0;
      awaddr_reg    <= 8'h00;
      wdata_reg     <= 32'h00000000;
      wstrb_reg     <= 4'h0;
      ctrl_reg      <= `ISR_RST_CTRL;
      exposure_reg  <= `ISR_RST_EXPOSURE;
      gain_reg      <= `ISR_RST_GAIN;
      black_reg     <= `ISR_RST_BLACK;
    end else begin
      s_axi_awready <= ~aw_have_reg & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~w_have_reg & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_have_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_have_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        // lanes travel with the data beat, not with the later decode
        wstrb_reg  <= s_axi_wstrb;
      end
      if (s_axi_bvalid & s_axi_bready) s_axi_bvalid <= 1'b0;
      if (wr_go) begin
        aw_have_reg  <= 1'b0;
        w_have_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `ISR_RESP_OKAY;
        // byte lane 0 carries every writable field except the upper exposure/black bits
        if (awaddr_reg == `ISR_OFS_CTRL) begin
          if (wstrb_reg[0]) ctrl_reg <= wdata_reg[`ISR_CTRL_W-1:0];
        end else if (awaddr_reg == `ISR_OFS_EXPOSURE) begin
          if (wstrb_reg[0]) exposure_reg[7:0] <= wdata_reg[7:0];
          if (wstrb_reg[1]) exposure_reg[10:8] <= wdata_reg[10:8];
        end else if (awaddr_reg == `ISR_OFS_GAIN) begin
          if (wstrb_reg[0]) gain_reg <= wdata_reg[7:0];
        end else if (awaddr_reg == `ISR_OFS_BLACK) begin
          if (wstrb_reg[0]) black_reg[7:0] <= wdata_reg[7:0];
          if (wstrb_reg[1]) black_reg[11:8] <= wdata_reg[11:8];
        end else if (awaddr_reg != `ISR_OFS_STATUS) begin
          s_axi_bresp <= `ISR_RESP_SLVERR;
        end
      end
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `ISR_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_rvalid & s_axi_rready) s_axi_rvalid <= 1'b0;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `ISR_RESP_OKAY;
        if (s_axi_araddr == `ISR_OFS_CTRL) begin
          s_axi_rdata <= {25'h0000000, ctrl_reg};
        end else if (s_axi_araddr == `ISR_OFS_EXPOSURE) begin
          s_axi_rdata <= {21'h000000, exposure_reg};
        end else if (s_axi_araddr == `ISR_OFS_GAIN) begin
          s_axi_rdata <= {24'h000000, gain_reg};
        end else if (s_axi_araddr == `ISR_OFS_BLACK) begin
          s_axi_rdata <= {20'h00000, black_reg};
        end else if (s_axi_araddr == `ISR_OFS_STATUS) begin
          s_axi_rdata <= {14'h0000, line_valid, frame_valid, frame_cnt_reg};
        end else begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `ISR_RESP_SLVERR;
        end
      end
    end
  end

  // ==================================================================
  // pixel step: sampled input clock edges, or internal half-rate tick
  reg  mclk_s1_reg, mclk_s2_reg, mclk_s3_reg;
  reg  oe_s1_reg, oe_s2_reg;
  reg  half_reg;
  reg  pend_reg;
  reg  step_d_reg;
  wire tick = pll_en ? half_reg : (mclk_s2_reg & ~mclk_s3_reg);

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mclk_s1_reg <= 1'b0;
      mclk_s2_reg <= 1'b0;
      mclk_s3_reg <= 1'b0;
      oe_s1_reg   <= 1'b1;
      oe_s2_reg   <= 1'b1;
      half_reg    <= 1'b0;
    end else begin
      mclk_s1_reg <= master_input_clock;
      mclk_s2_reg <= mclk_s1_reg;
      mclk_s3_reg <= mclk_s2_reg;
      oe_s1_reg   <= oe_b;
      oe_s2_reg   <= oe_s1_reg;
      // at most one step per two clocks keeps the pixel rate below the cap
      half_reg    <= ~half_reg;
    end
  end

  // ==================================================================
  // frame timing
  reg  [2:0]  state_reg;
  reg  [10:0] col_reg;
  reg  [10:0] line_reg;
  reg         phase_reg;
  reg  [15:0] long_reg;
  reg         long_sat_reg;
  wire [10:0] lines_total = emb_en ? ROWS_W + EMB_N + EMB_N : ROWS_W;
  wire        emb_line = emb_en & ((line_reg < EMB_N) | (line_reg >= ROWS_W + EMB_N));
  wire [10:0] img_row = emb_en ? line_reg - EMB_N : line_reg;
  wire        need = (state_reg == S_LINE) & ~emb_line;
  wire [11:0] fifo_data;
  wire        fifo_valid;
  // no step right after a step: the pixel clock must stay high one cycle
  wire        pop = pend_reg & ~step_d_reg & need & fifo_valid;
  wire        adv = pend_reg & ~step_d_reg & (~need | (fifo_valid & (~hdr_en | phase_reg)));

  isr_fifo #(.W(12), .D(4), .AW(2)) u_fifo (
    .clk       (clk),
    .rst_b     (rst_b),
    .in_data   (adc_sample),
    .in_valid  (adc_valid),
    .in_ready  (adc_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (pop)
  );

  // ==================================================================
  // sample correction and gain
  wire [11:0] corr = (fifo_data > black_reg) ? fifo_data - black_reg : 12'h000;
  wire [19:0] prod = corr * gain_reg;
  wire [15:0] lin16 = {1'b0, prod[19:`ISR_GAIN_SHIFT]};
  wire [15:0] short16 = (lin16[15:12] != 4'h0) ? 16'hFFFF : {lin16[11:0], 4'h0};
  // long exposure clipped at full scale: take the scaled short one instead
  wire [15:0] merged = long_sat_reg ? short16 : long_reg;
  wire [15:0] pix16 = hdr_en ? merged : lin16;

  function [11:0] squeeze;
    input [15:0] v;
    reg   [15:0] d;
    begin
      d = 16'h0000;
      if (v < 16'h0400) begin
        squeeze = v[11:0];
      end else if (v < 16'h1000) begin
        d = v - 16'h0400;
        squeeze = 12'h400 + {2'b00, d[11:2]};
      end else if (v < 16'h4000) begin
        d = v - 16'h1000;
        squeeze = 12'h700 + {2'b00, d[13:4]};
      end else begin
        d = v - 16'h4000;
        squeeze = 12'hA00 + {1'b0, d[15:5]};
      end
    end
  endfunction

  wire [11:0] pix12 = comp_en ? squeeze(pix16) :
                      hdr_en ? pix16[15:4] :
                      (pix16[15:12] != 4'h0) ? 12'hFFF : pix16[11:0];

  reg [11:0] emb_word;
  always @* begin
    case (col_reg[2:0])
      3'd0: emb_word = {5'h00, ctrl_reg};
      3'd1: emb_word = {1'b0, exposure_reg};
      3'd2: emb_word = {4'h0, gain_reg};
      3'd3: emb_word = frame_cnt_reg[11:0];
      3'd4: emb_word = hist_reg[0][15:4];
      3'd5: emb_word = hist_reg[1][15:4];
      3'd6: emb_word = hist_reg[2][15:4];
      default: emb_word = hist_reg[3][15:4];
    endcase
  end

  wire [10:0] exp_sum = img_row + exposure_reg;
  wire [10:0] rst_row = (exp_sum >= ROWS_W) ? exp_sum - ROWS_W : exp_sum;
  wire        oe_on = ~oe_s2_reg;
  integer i;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= S_VB;
      col_reg <= 11'h000;
      line_reg <= 11'h000;
      pend_reg <= 1'b0;
      step_d_reg <= 1'b0;
      phase_reg <= 1'b0;
      long_reg <= 16'h0000;
      long_sat_reg <= 1'b0;
      frame_cnt_reg <= 16'h0000;
      pixel_data_out <= 12'h000;
      frame_valid <= 1'b0;
      line_valid <= 1'b0;
      pixel_out_clock <= 1'b0;
      par_oe <= 1'b0;
      row_reset_strobe <= 1'b0;
      row_reset_addr <= 11'h000;
      row_read_strobe <= 1'b0;
      row_read_addr <= 11'h000;
      shutter_ctrl <= 1'b0;
      raised_common_mode_sel <= 1'b0;
      for (i = 0; i < 4; i = i + 1) hist_reg[i] <= 16'h0000;
    end else begin
      pend_reg <= tick | (pend_reg & ~adv);
      step_d_reg <= adv;
      shutter_ctrl <= ctrl_reg[`ISR_CTRL_SHUTTER];
      raised_common_mode_sel <= ctrl_reg[`ISR_CTRL_RCM];
      par_oe <= oe_on;
      row_reset_strobe <= 1'b0;
      row_read_strobe <= 1'b0;
      // low on the step cycle, high next: data settle before the rising edge
      pixel_out_clock <= oe_on & ~adv;
      if (pop & hdr_en & ~phase_reg) begin
        phase_reg <= 1'b1;
        long_reg <= lin16;
        long_sat_reg <= (fifo_data == 12'hFFF);
      end
      if (adv) begin
        phase_reg <= 1'b0;
        frame_valid <= oe_on & (state_reg != S_VB);
        line_valid <= oe_on & (state_reg == S_LINE);
        pixel_data_out <= 12'h000;
        case (state_reg)
          S_VB: begin
            if (col_reg >= VB_L) begin
              col_reg <= 11'h000;
              if (stream_en) state_reg <= S_LINE;
            end else begin
              col_reg <= col_reg + 11'h001;
            end
          end
          S_LINE: begin
            if (emb_line) begin
              pixel_data_out <= oe_on ? emb_word : 12'h000;
            end else begin
              pixel_data_out <= oe_on ? pix12 : 12'h000;
              hist_reg[pix12[11:10]] <= hist_reg[pix12[11:10]] + 16'h0001;
            end
            if (col_reg == 11'h000 && !emb_line) begin
              row_read_strobe <= 1'b1;
              row_read_addr <= img_row;
              row_reset_strobe <= 1'b1;
              row_reset_addr <= rst_row;
            end
            if (col_reg == COLS_L) begin
              col_reg <= 11'h000;
              state_reg <= S_HB;
            end else begin
              col_reg <= col_reg + 11'h001;
            end
          end
          S_HB: begin
            if (col_reg >= HB_L) begin
              col_reg <= 11'h000;
              if (line_reg + 11'h001 >= lines_total) begin
                line_reg <= 11'h000;
                state_reg <= S_VB;
                frame_cnt_reg <= frame_cnt_reg + 16'h0001;
              end else begin
                line_reg <= line_reg + 11'h001;
                state_reg <= S_LINE;
              end
            end else begin
              col_reg <= col_reg + 11'h001;
            end
          end
          default: begin
            state_reg <= S_VB;
            col_reg <= 11'h000;
          end
        endcase
        if (state_reg == S_VB && col_reg == 11'h000) begin
          for (i = 0; i < 4; i = i + 1) hist_reg[i] <= 16'h0000;
        end
      end
      // a disabled port shows no stale pixel or qualifier
      if (!oe_on) begin
        pixel_data_out <= 12'h000;
        frame_valid <= 1'b0;
        line_valid <= 1'b0;
      end
    end
  end
endmodule // isr_readout

// ==== isr_readout_sva.sv ====
`timescale 1ns/100ps
// ====================================================================
// port-level checks for the readout block
module isr_readout_sva (
  input wire        clk,
  input wire        rst_b,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        oe_b,
  input wire [11:0] pixel_data_out,
  input wire        frame_valid,
  input wire        line_valid,
  input wire        pixel_out_clock,
  input wire        par_oe,
  input wire        row_read_strobe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ==================================================================
  // register bus
  a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:4] s_axi_bvalid)
    else $error("write response missing");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  // ==================================================================
  // pixel port
  // five samples: the release edge itself still runs the reset branch
  a_oe_enables: assert property (!oe_b [*5] |-> par_oe)
    else $error("outputs not enabled");
  a_oe_gates: assert property (!par_oe [*2] |-> !pixel_out_clock && pixel_data_out == 12'h000)
    else $error("outputs driven while disabled");
  a_pclk_low_one: assert property ($fell(pixel_out_clock) |=> pixel_out_clock || !par_oe)
    else $error("pixel clock low too long");
  a_data_hold: assert property (pixel_out_clock && $past(pixel_out_clock) |-> $stable(pixel_data_out) && $stable(line_valid))
    else $error("data changed while pixel clock high");
  a_line_in_frame: assert property (line_valid |-> frame_valid)
    else $error("line qualifier outside frame");
  a_idle_data: assert property (!line_valid |-> pixel_data_out == 12'h000)
    else $error("data not zero outside line");
  a_hblank_gap: assert property ($fell(line_valid) |-> !line_valid [*2])
    else $error("no horizontal blanking");
  a_vblank_gap: assert property ($fell(frame_valid) |-> !frame_valid [*2])
    else $error("no vertical blanking");
  a_row_pulse: assert property (row_read_strobe |=> !row_read_strobe)
    else $error("row strobe longer than a cycle");
  c_frame_end: cover property ($fell(frame_valid));
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
  c_row_read: cover property (row_read_strobe);
endmodule // isr_readout_sva

bind isr_readout isr_readout_sva u_sva (.clk, .rst_b, .s_axi_awvalid, .s_axi_awready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .oe_b, .pixel_data_out, .frame_valid, .line_valid,
  .pixel_out_clock, .par_oe, .row_read_strobe);

// ==== isr_regs.vh ====
`ifndef ISR_REGS_VH
`define ISR_REGS_VH
// ====================================================================
// register offsets (byte addresses, one aligned word each)
`define ISR_OFS_CTRL      8'h00
`define ISR_OFS_EXPOSURE  8'h04
`define ISR_OFS_GAIN      8'h08
`define ISR_OFS_BLACK     8'h0C
`define ISR_OFS_STATUS    8'h10
// ====================================================================
// control register fields
`define ISR_CTRL_STREAM   0
`define ISR_CTRL_PLL      1
`define ISR_CTRL_EMB      2
`define ISR_CTRL_HDR      3
`define ISR_CTRL_COMP     4
`define ISR_CTRL_SHUTTER  5
`define ISR_CTRL_RCM      6
`define ISR_CTRL_W        7
// ====================================================================
// reset values
`define ISR_RST_CTRL      7'h00
`define ISR_RST_EXPOSURE  11'h010
`define ISR_RST_GAIN      8'h20
`define ISR_RST_BLACK     12'h000
// ====================================================================
// geometry and timing counts (in pixel steps)
`define ISR_COLS          1928
`define ISR_ROWS          1088
`define ISR_HBLANK        16
`define ISR_VBLANK        4
`define ISR_EMB_LINES     2
`define ISR_GAIN_SHIFT    5
`define ISR_RESP_OKAY     2'b00
`define ISR_RESP_SLVERR   2'b10
`endif

// ==== test_isr_readout.sv ====
`timescale 1ns/100ps
`include "isr_regs.vh"
module test_isr_readout;
  localparam ROWS = 4;
  localparam COLS = 8;
  logic        clk = 0, rst_b = 0, mclk = 0, oe_b = 0, feed = 0, sv = 0;
  logic        awv = 0, wv = 0, br = 0, arv = 0, rr = 0, emb = 0, cmp = 0;
  logic [7:0]  awa = 0, ara = 0;
  logic [31:0] wd = 0, rdd, rd;
  logic [11:0] smp = 0, pdo, hd;
  logic [1:0]  bresp, rresp, resp;
  logic        awr, wrdy, bv, arr, rv, sr, fv, lv, pclk, poe, rss, rds, shut, rcm, hs, eol, eof;
  logic [10:0] rsa, rda;
  logic [15:0] hc, hl, ecols, elines;
  logic [11:0] q[$];
  logic [11:0] ev[3];
  logic [31:0] dflt[4] = '{`ISR_RST_CTRL, `ISR_RST_EXPOSURE, `ISR_RST_GAIN, `ISR_RST_BLACK};
  int n_errors = 0, checked = 0, cyc = 0, nfr = 0, nrow = 0, n0, gain = 32, blk = 0, expo = 3;

  isr_readout #(.COLS(COLS), .ROWS(ROWS), .HBLANK(2), .VBLANK(2)) u_dut (
    .clk(clk), .rst_b(rst_b), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdd), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rr), .master_input_clock(mclk), .oe_b(oe_b),
    .adc_sample(smp), .adc_valid(sv), .adc_ready(sr), .pixel_data_out(pdo),
    .frame_valid(fv), .line_valid(lv), .pixel_out_clock(pclk), .par_oe(poe),
    .row_reset_strobe(rss), .row_reset_addr(rsa), .row_read_strobe(rds),
    .row_read_addr(rda), .shutter_ctrl(shut), .raised_common_mode_sel(rcm));
  isr_host_rx u_host (.clk(clk), .rst_b(rst_b), .pixel_out_clock(pclk), .frame_valid(fv),
    .line_valid(lv), .pixel_data_out(pdo), .px_stb(hs), .px_data(hd), .px_col(hc),
    .px_line(hl), .eol_stb(eol), .eof_stb(eof), .n_cols(ecols), .n_lines(elines));

  initial forever #12.5 clk = ~clk;
  // link clock is free running at one eighth of clk, each edge 0.5 ns ahead of a clk rising edge
  initial begin
    #37;
    forever #100 mclk = ~mclk;
  end
  // ==================================================================
  // checking and bus tasks
  task test_done;
    $display("checked %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task axw(input logic [7:0] a, input logic [31:0] d);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
    end while (!bv);
    resp = bresp;
    br <= 1'b0;
    @(posedge clk);
  endtask
  task axr(input logic [7:0] a);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    rd = rdd;
    resp = rresp;
    rr <= 1'b0;
    @(posedge clk);
  endtask
  // linear path: black subtract, gain in 1/32 steps, then clip or compress
  function logic [11:0] px(input logic [11:0] s);
    int v;
    v = (s > blk) ? ((s - blk) * gain) >> 5 : 0;
    if (!cmp) return (v > 4095) ? 12'hFFF : v[11:0];
    if (v < 'h400) return v[11:0];
    if (v < 'h1000) return 12'('h400 + (v - 'h400) / 4);
    if (v < 'h4000) return 12'('h700 + (v - 'h1000) / 16);
    return 12'('hA00 + (v - 'h4000) / 32);
  endfunction
  // ==================================================================
  // converter feed, pixel, line, frame and row monitors
  always @(posedge clk) if (feed) begin
    if (sv && sr) q.push_back(smp);
    if (!sv || sr) begin
      sv <= ($urandom % 4) != 0;
      smp <= 12'($urandom);
    end
  end
  always @(posedge clk) if (hs) begin
    if (emb && (hl < 2 || hl >= ROWS + 2)) begin
      if (hl == 0 && hc < 3) chk("embedded word", ev[hc], hd);
    end else if (q.size() == 0) chk("pixel present", 1, 0);
    else chk("pixel", px(q.pop_front()), hd);
  end
  always @(posedge clk) if (eol) chk("line length", COLS, ecols);
  always @(posedge clk) if (eof) begin
    nfr++;
    chk("lines per frame", emb ? ROWS + 4 : ROWS, elines);
  end
  always @(posedge clk) if (rds) begin
    chk("read row", nrow, rda);
    chk("reset row", (nrow + expo) % ROWS, rsa);
    nrow = (nrow + 1) % ROWS;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      $display("[FAIL] run time expected under 20000 seen 20000");
      test_done();
    end
  end
  // ==================================================================
  // main sequence
  initial begin
    void'($urandom(45));
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      axr(8'(4 * i));
      chk("reset value", dflt[i], rd);
    end
    axr(8'h14);
    chk("unmapped read data", 0, rd);
    chk("unmapped read resp", `ISR_RESP_SLVERR, resp);
    axw(8'h14, 32'h1);
    chk("unmapped write", `ISR_RESP_SLVERR, resp);
    axw(`ISR_OFS_STATUS, 32'hFFFF);
    chk("status write", `ISR_RESP_OKAY, resp);
    gain = $urandom_range(80, 33);
    blk = $urandom_range(255, 1);
    ev = '{12'h077, 12'(expo), 12'(gain)};
    axw(`ISR_OFS_EXPOSURE, expo);
    axw(`ISR_OFS_GAIN, gain);
    axw(`ISR_OFS_BLACK, blk);
    axr(`ISR_OFS_GAIN);
    chk("gain readback", gain, rd);
    axr(`ISR_OFS_BLACK);
    chk("black readback", blk, rd);
    axw(`ISR_OFS_CTRL, 32'h21);
    feed <= 1'b1;
    repeat (3) @(posedge clk);
    chk("shutter output", 1, shut);
    while (nfr < 2) @(posedge clk);
    // stop streaming: the frame in flight ends, none follows, buffer fills
    axw(`ISR_OFS_CTRL, 32'h20);
    repeat (1000) @(posedge clk);
    n0 = nfr;
    repeat (600) @(posedge clk);
    chk("frames while stopped", n0, nfr);
    chk("buffer full", 0, sr);
    axr(`ISR_OFS_STATUS);
    chk("frame count", n0, rd);
    // modes change only while stopped, so buffered samples meet the new mode
    emb = 1'b1;
    cmp = 1'b1;
    axw(`ISR_OFS_CTRL, 32'h77);
    repeat (3) @(posedge clk);
    chk("common mode select", 1, rcm);
    while (nfr < n0 + 2) @(posedge clk);
    // stop again so the enable test falls in vertical blanking
    axw(`ISR_OFS_CTRL, 32'h76);
    repeat (600) @(posedge clk);
    oe_b <= 1'b1;
    repeat (6) @(posedge clk);
    chk("disabled outputs", 0, {poe, pclk, pdo});
    oe_b <= 1'b0;
    repeat (6) @(posedge clk);
    chk("enabled outputs", 1, poe);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      axr(8'(4 * i));
      chk("default after reset", dflt[i], rd);
    end
    chk("shutter after reset", 0, shut);
    test_done();
  end
endmodule // test_isr_readout
